// file: hdl/sms_pkg.sv
// constants, types and register map of the stop-mode sequencer
package sms_pkg;

	// register offsets
	localparam logic [7:0] ADDR_POWER_MODE_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PERIODIC_WAKE   = 8'h01;
	localparam logic [7:0] ADDR_STATUS          = 8'h02;

	// power_mode_ctrl_reg fields
	localparam int BIT_STOP_ENABLE    = 0;
	localparam int BIT_DEEP_SEL       = 1;
	localparam int BIT_LOWV_ENABLE    = 2;
	localparam int BIT_LOWV_STOP_EN   = 3;
	localparam int BIT_LATCH_RELEASE  = 4;
	localparam int BIT_WAKE_FLAG      = 5;

	// periodic_wake_ctrl_reg fields
	localparam int BIT_WSEL_LO        = 0;
	localparam int BIT_OSC_RUN_STOP   = 3;
	localparam int BIT_DEBUG_ALLOW    = 4;

	// status fields
	localparam int BIT_MODE_LO        = 0;
	localparam int BIT_DEBUG_ACTIVE   = 2;
	localparam int BIT_LATCH_HOLD     = 3;

	// values after reset
	localparam logic       RST_STOP_ENABLE = 1'b0;
	localparam logic       RST_DEEP_SEL    = 1'b0;
	localparam logic       RST_LOWV_ENABLE  = 1'b0;
	localparam logic       RST_LOWV_STOP_EN = 1'b0;
	localparam logic [2:0] RST_WAKE_SEL    = 3'h0;
	localparam logic       RST_OSC_RUN     = 1'b0;
	localparam logic       RST_DEBUG_ALLOW = 1'b0;

	// timing of the wake source, divided down from the system clock
	localparam int CLK_PERIOD_NS   = 20;
	localparam int WAKE_TICK_NS    = 1000000;
	localparam int WAKE_TICK_CYCLES = WAKE_TICK_NS / CLK_PERIOD_NS;
	localparam logic [9:0] WAKE_BASE_MS = 10'h008;

	typedef enum logic [1:0] {
		MODE_RUN   = 2'b00,
		MODE_LIGHT = 2'b01,
		MODE_DEEP  = 2'b10
	} sms_mode_t;

	typedef enum logic [2:0] {
		VEC_NONE  = 3'b000,
		VEC_RESET = 3'b001,
		VEC_IRQ   = 3'b010,
		VEC_KEYPD = 3'b011,
		VEC_WAKE  = 3'b100,
		VEC_SERIAL = 3'b101,
		VEC_CONV  = 3'b110,
		VEC_LOWV  = 3'b111
	} sms_vec_t;

endpackage

// file: hdl/sms_top.sv
// stop-mode sequencer: mode choice, clock and regulator control, pin latches, wake-up
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module sms_top
	import sms_pkg::*;
#(
	parameter int TICK_CYCLES = WAKE_TICK_CYCLES
) (
	input  wire logic       i_clk_sys,
	input  wire logic       i_resetn,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	input  wire logic       i_stop_exec,
	input  wire logic       i_reset_pin_n,
	input  wire logic       i_irq_pin,
	input  wire logic       i_irq_pol_high,
	input  wire logic       i_keypad_act,
	input  wire logic       i_serial_rx_int,
	input  wire logic       i_conv_int,
	input  wire logic       i_lowv_int,
	input  wire logic       i_dbg_halt_cmd,
	input  wire logic       i_dbg_go_cmd,
	input  wire logic       i_dbg_status_cmd,
	output logic [7:0]      o_rdata,
	output logic [1:0]      o_mode,
	output logic            o_clk_en_cpu,
	output logic            o_clk_en_periph,
	output logic            o_clk_en_dbg,
	output logic            o_osc_run,
	output logic            o_reg_full,
	output logic            o_pin_hold,
	output logic            o_pin_port_ctl,
	output logic            o_sys_reset,
	output logic            o_illegal_reset,
	output logic            o_wake_int,
	output logic [2:0]      o_vector,
	output logic            o_dbg_active,
	output logic            o_dbg_status_err
);
	typedef struct packed {
		sms_mode_t  mode;
		logic       stop_en;
		logic       deep_sel;
		logic       lowv_en;
		logic       lowv_stop_en;
		logic [2:0] wsel;
		logic       osc_stop_en;
		logic       dbg_allow;
		logic       wake_flag;
		logic       latch_hold;
		logic [7:0] rdata;
		logic       rst_s1;
		logic       rst_s2;
		logic       irq_s1;
		logic       irq_s2;
		logic       kp_s1;
		logic       kp_s2;
		logic       clk_cpu;
		logic       clk_periph;
		logic       clk_dbg;
		logic       osc_run;
		logic       reg_full;
		logic       sys_reset;
		logic       illegal_rst;
		logic       wake_int;
		sms_vec_t   vec;
		logic       dbg_active;
		logic       dbg_err;
	} sms_state_t;

	sms_state_t q;
	sms_state_t d;
	sms_wake_if wk ();

	// a zero tick count would leave the wake divider with no period at all
	generate
		if (TICK_CYCLES < 1) begin : g_bad_tick
			$error("wake tick count must be at least one");
		end
	endgenerate

	sms_wake_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_wake (
		.i_clk_sys (i_clk_sys),
		.i_resetn  (i_resetn),
		.wk        (wk.tmr)
	);

	assign wk.sel = q.wsel;

	logic lowv_in_stop;
	logic irq_light;
	logic rst_pin;
	logic in_stop;
	logic wr_pwr;

	always_comb begin
		d = q;
		lowv_in_stop = q.lowv_en & q.lowv_stop_en;
		irq_light   = i_irq_pol_high ? q.irq_s2 : ~q.irq_s2;
		rst_pin     = ~q.rst_s2;
		in_stop     = (q.mode != MODE_RUN);
		wr_pwr      = i_wr && (i_addr == ADDR_POWER_MODE_CTRL);

		// pins come from outside: two flops before any use
		d.rst_s1 = i_reset_pin_n;
		d.rst_s2 = q.rst_s1;
		d.irq_s1 = i_irq_pin;
		d.irq_s2 = q.irq_s1;
		d.kp_s1  = i_keypad_act;
		d.kp_s2  = q.kp_s1;

		d.sys_reset   = 1'b0;
		d.illegal_rst = 1'b0;
		d.wake_int    = 1'b0;
		d.vec         = VEC_NONE;
		d.dbg_err     = 1'b0;

		// register writes
		if (wr_pwr) begin
			d.stop_en     = i_wdata[BIT_STOP_ENABLE];
			d.deep_sel    = i_wdata[BIT_DEEP_SEL];
			d.lowv_en      = i_wdata[BIT_LOWV_ENABLE];
			d.lowv_stop_en = i_wdata[BIT_LOWV_STOP_EN];
			if (i_wdata[BIT_LATCH_RELEASE]) begin
				// opening the latches hands pins back to port/peripheral logic
				d.latch_hold = 1'b0;
				d.wake_flag  = 1'b0;
			end
		end
		if (i_wr && (i_addr == ADDR_PERIODIC_WAKE)) begin
			d.wsel        = i_wdata[BIT_WSEL_LO +: 3];
			d.osc_stop_en = i_wdata[BIT_OSC_RUN_STOP];
			d.dbg_allow   = i_wdata[BIT_DEBUG_ALLOW];
		end
		if (i_dbg_go_cmd && q.mode == MODE_RUN) begin
			d.dbg_active = 1'b0;
		end

		case (q.mode)
			MODE_RUN: begin
				if (rst_pin) begin
					d.sys_reset = 1'b1;
					d.vec       = VEC_RESET;
				end else if (i_stop_exec) begin
					if (!q.stop_en) begin
						d.illegal_rst = 1'b1;
						d.sys_reset   = 1'b1;
						d.vec         = VEC_RESET;
					end else if (q.deep_sel && !lowv_in_stop && !q.dbg_allow) begin
						d.mode       = MODE_DEEP;
						d.latch_hold = 1'b1;
					end else begin
						// detector or debug in stop cannot survive the deep power-down
						d.mode = MODE_LIGHT;
					end
				end
			end
			MODE_DEEP: begin
				// only these three sources can wake the powered-down core
				if (rst_pin || !q.irq_s2 || wk.wake) begin
					d.mode        = MODE_RUN;
					d.sys_reset   = 1'b1;
					d.vec         = VEC_RESET;
					d.wake_flag   = 1'b1;
					d.latch_hold  = 1'b1;
				end
			end
			MODE_LIGHT: begin
				if (rst_pin) begin
					d.mode      = MODE_RUN;
					d.sys_reset = 1'b1;
					d.vec       = VEC_RESET;
				end else if (q.dbg_allow && i_dbg_halt_cmd) begin
					d.mode       = MODE_RUN;
					d.dbg_active = 1'b1;
				end else if (irq_light || q.kp_s2 || wk.wake || i_serial_rx_int
						|| i_conv_int || i_lowv_int) begin
					d.mode     = MODE_RUN;
					d.wake_int = 1'b1;
					if (irq_light) begin
						d.vec = VEC_IRQ;
					end else if (q.kp_s2) begin
						d.vec = VEC_KEYPD;
					end else if (wk.wake) begin
						d.vec = VEC_WAKE;
					end else if (i_serial_rx_int) begin
						d.vec = VEC_SERIAL;
					end else if (i_conv_int) begin
						d.vec = VEC_CONV;
					end else begin
						d.vec = VEC_LOWV;
					end
				end
			end
			default: begin
				d.mode = MODE_RUN;
			end
		endcase

		// memory commands with status cannot touch memory while stopped
		if (in_stop && i_dbg_status_cmd) begin
			d.dbg_err = 1'b1;
		end

		// a system reset returns software-visible control to defaults;
		// the wake flag and latches survive so recovery code can find them
		if (d.sys_reset) begin
			d.stop_en     = RST_STOP_ENABLE;
			d.deep_sel    = RST_DEEP_SEL;
			d.lowv_en      = RST_LOWV_ENABLE;
			d.lowv_stop_en = RST_LOWV_STOP_EN;
			d.wsel        = RST_WAKE_SEL;
			d.osc_stop_en = RST_OSC_RUN;
			d.dbg_allow   = RST_DEBUG_ALLOW;
			d.dbg_active  = 1'b0;
		end

		// clock and power outputs follow the next mode
		d.clk_cpu    = (d.mode == MODE_RUN);
		d.clk_periph = (d.mode == MODE_RUN);
		d.clk_dbg    = (d.mode == MODE_RUN) || q.dbg_allow;
		d.osc_run    = (d.mode == MODE_RUN) || ((d.mode == MODE_LIGHT)
			&& (q.osc_stop_en || q.dbg_allow));
		d.reg_full   = (d.mode == MODE_RUN) || q.dbg_allow || lowv_in_stop;

		// read data stands in the cycle after the strobe only
		d.rdata = 8'h00;
		if (i_rd) begin
			case (i_addr)
				ADDR_POWER_MODE_CTRL: begin
					d.rdata[BIT_STOP_ENABLE] = q.stop_en;
					d.rdata[BIT_DEEP_SEL]    = q.deep_sel;
					d.rdata[BIT_LOWV_ENABLE]  = q.lowv_en;
					d.rdata[BIT_LOWV_STOP_EN] = q.lowv_stop_en;
					d.rdata[BIT_WAKE_FLAG]   = q.wake_flag;
				end
				ADDR_PERIODIC_WAKE: begin
					d.rdata[BIT_WSEL_LO +: 3]    = q.wsel;
					d.rdata[BIT_OSC_RUN_STOP]  = q.osc_stop_en;
					d.rdata[BIT_DEBUG_ALLOW]   = q.dbg_allow;
				end
				ADDR_STATUS: begin
					d.rdata[BIT_MODE_LO +: 2]  = q.mode;
					d.rdata[BIT_DEBUG_ACTIVE]  = q.dbg_active;
					d.rdata[BIT_LATCH_HOLD]    = q.latch_hold;
				end
				default: begin
					d.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			q             <= '0;
			q.mode        <= MODE_RUN;
			q.vec         <= VEC_NONE;
			q.stop_en     <= RST_STOP_ENABLE;
			q.deep_sel    <= RST_DEEP_SEL;
			q.lowv_en      <= RST_LOWV_ENABLE;
			q.lowv_stop_en <= RST_LOWV_STOP_EN;
			q.wsel        <= RST_WAKE_SEL;
			q.osc_stop_en <= RST_OSC_RUN;
			q.dbg_allow   <= RST_DEBUG_ALLOW;
			q.rst_s1      <= 1'b1;
			q.rst_s2      <= 1'b1;
			q.irq_s1      <= 1'b1;
			q.irq_s2      <= 1'b1;
			q.clk_cpu     <= 1'b1;
			q.clk_periph  <= 1'b1;
			q.clk_dbg     <= 1'b1;
			q.osc_run     <= 1'b1;
			q.reg_full    <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign o_rdata          = q.rdata;
	assign o_mode           = q.mode;
	assign o_clk_en_cpu     = q.clk_cpu;
	assign o_clk_en_periph  = q.clk_periph;
	assign o_clk_en_dbg     = q.clk_dbg;
	assign o_osc_run        = q.osc_run;
	assign o_reg_full       = q.reg_full;
	assign o_pin_hold       = q.latch_hold;
	assign o_pin_port_ctl   = ~q.latch_hold;
	assign o_sys_reset      = q.sys_reset;
	assign o_illegal_reset  = q.illegal_rst;
	assign o_wake_int       = q.wake_int;
	assign o_vector         = q.vec;
	assign o_dbg_active     = q.dbg_active;
	assign o_dbg_status_err = q.dbg_err;
endmodule // sms_top

// file: hdl/sms_wake_if.sv
// link between the sequencer and its periodic wake timer
`timescale 1ns/1ps
interface sms_wake_if;
	logic [2:0] sel;
	logic       wake;

	modport ctl (output sel, input wake);
	modport tmr (input sel, output wake);
endinterface

// file: hdl/sms_wake_timer.sv
// periodic wake timer driven by a 1 kHz enable derived from the system clock
`timescale 1ns/1ps
module sms_wake_timer
	import sms_pkg::*;
#(
	parameter int TICK_CYCLES = WAKE_TICK_CYCLES
) (
	input  wire logic i_clk_sys,
	input  wire logic i_resetn,
	sms_wake_if.tmr   wk
);
	localparam int DW = $clog2(TICK_CYCLES + 1);

	generate
		if (TICK_CYCLES < 1) begin : g_bad
			$error("tick count must be at least one");
		end
	endgenerate

	typedef struct packed {
		logic [DW-1:0] div;
		logic [9:0]    ms;
		logic          wake;
	} sms_tmr_st_t;

	sms_tmr_st_t q;
	sms_tmr_st_t d;
	logic [9:0]  lim;

	assign lim = 10'((WAKE_BASE_MS << wk.sel) - 10'h001);
	assign wk.wake = q.wake;

	always_comb begin
		d = q;
		d.wake = 1'b0;
		if (wk.sel == 3'h0) begin
			// source held idle to save power, so no wake can be produced
			d.div = '0;
			d.ms = 10'h000;
		end else if (d.div == DW'(TICK_CYCLES - 1)) begin
			d.div = '0;
			if (q.ms >= lim) begin
				d.ms = 10'h000;
				d.wake = 1'b1;
			end else begin
				d.ms = 10'(q.ms + 10'h001);
			end
		end else begin
			d.div = DW'(q.div + 1'b1);
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule // sms_wake_timer

// file: verif/sms_assertions.sv
// concurrent checks on the stop-mode sequencer ports, bound into the top
`timescale 1ns/1ps
module sms_checker
	import sms_pkg::*;
#(
	parameter int TICK_CYCLES = WAKE_TICK_CYCLES
) (
	input logic       i_clk_sys,
	input logic       i_resetn,
	input logic [7:0] i_addr,
	input logic [7:0] i_wdata,
	input logic       i_wr,
	input logic       i_stop_exec,
	input logic       i_dbg_status_cmd,
	input logic [1:0] o_mode,
	input logic       o_clk_en_cpu,
	input logic       o_clk_en_periph,
	input logic       o_clk_en_dbg,
	input logic       o_osc_run,
	input logic       o_reg_full,
	input logic       o_pin_hold,
	input logic       o_pin_port_ctl,
	input logic       o_sys_reset,
	input logic       o_illegal_reset,
	input logic       o_wake_int,
	input logic [2:0] o_vector,
	input logic       o_dbg_status_err
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);

	stop_entry_a: assert property (o_mode != 2'b00 && $past(o_mode) == 2'b00
		|-> $past(i_stop_exec))
		else $error("stop mode entered without a stop request");
	clk_halt_a: assert property (o_mode != 2'b00 |-> !o_clk_en_cpu && !o_clk_en_periph)
		else $error("cpu or peripheral clock running in stop");
	illegal_pair_a: assert property (o_illegal_reset |-> o_sys_reset && o_vector == 3'h1)
		else $error("illegal reset without system reset vector");
	deep_quiet_a: assert property (o_mode == 2'b10
		|-> !o_clk_en_dbg && !o_reg_full && !o_osc_run)
		else $error("deep stop with debug clock, regulator or oscillator on");
	latch_entry_a: assert property ($rose(o_pin_hold)
		|-> o_mode == 2'b10 && !o_pin_port_ctl)
		else $error("pin latch closed outside deep stop entry");
	latch_keep_a: assert property (o_pin_hold
		&& !(i_wr && i_addr == 8'h00 && i_wdata[4]) |=> o_pin_hold)
		else $error("pin latch opened without release write");
	deep_exit_a: assert property ($past(o_mode) == 2'b10 && o_mode == 2'b00
		|-> o_sys_reset && o_vector == 3'h1 && o_pin_hold)
		else $error("deep stop left without reset or with open latch");
	light_wake_a: assert property (o_wake_int |-> o_vector != 3'h0 && !o_sys_reset
		&& $past(o_mode) == 2'b01)
		else $error("interrupt wake with reset, no vector or not from light stop");
	status_err_a: assert property (o_mode != 2'b00 && i_dbg_status_cmd
		|=> o_dbg_status_err)
		else $error("status command in stop gave no error");

	cov_deep_exit: cover property ($past(o_mode) == 2'b10 && o_mode == 2'b00);
	cov_light_int: cover property (o_wake_int);
	cov_illegal: cover property (o_illegal_reset);
endmodule // sms_checker

bind sms_top sms_checker #(.TICK_CYCLES(TICK_CYCLES)) u_sms_checker (
	.i_clk_sys, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_stop_exec, .i_dbg_status_cmd,
	.o_mode, .o_clk_en_cpu, .o_clk_en_periph, .o_clk_en_dbg, .o_osc_run, .o_reg_full,
	.o_pin_hold, .o_pin_port_ctl, .o_sys_reset, .o_illegal_reset, .o_wake_int,
	.o_vector, .o_dbg_status_err
);

// file: verif/stop_mode_sequencer_test.sv
// self-checking bench for the stop-mode sequencer
`timescale 1ns/1ps
module stop_mode_sequencer_test;
	import sms_pkg::*;
	logic       i_clk_sys = 0, i_resetn = 0, i_wr = 0, i_rd = 0, i_stop_exec = 0;
	logic       i_reset_pin_n = 1, i_irq_pin = 1, i_irq_pol_high = 0, i_keypad_act = 0;
	logic       i_serial_rx_int = 0, i_conv_int = 0, i_lowv_int = 0;
	logic       i_dbg_halt_cmd = 0, i_dbg_go_cmd = 0, i_dbg_status_cmd = 0;
	logic [7:0] i_addr = 0, i_wdata = 0, o_rdata, r = 8'h52;
	logic [1:0] o_mode;
	logic [2:0] o_vector;
	logic       o_clk_en_cpu, o_clk_en_periph, o_clk_en_dbg, o_osc_run, o_reg_full;
	logic       o_pin_hold, o_pin_port_ctl, o_sys_reset, o_illegal_reset, o_wake_int;
	logic       o_dbg_active, o_dbg_status_err;
	int         bad_count = 0, total_checks = 0;
	// packed views so one compare covers a whole state
	wire [7:0]  st = {o_mode, o_clk_en_cpu, o_clk_en_periph, o_clk_en_dbg, o_osc_run,
		o_reg_full, o_pin_hold};
	wire [7:0]  ev = {o_sys_reset, o_illegal_reset, o_wake_int, o_dbg_active,
		o_pin_port_ctl, o_vector};

	always #10 i_clk_sys = ~i_clk_sys;

	// short tick keeps the periodic wake at 64 cycles for select 1
	sms_top #(.TICK_CYCLES(4)) u_sms_top (
		.i_clk_sys, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .i_stop_exec,
		.i_reset_pin_n, .i_irq_pin, .i_irq_pol_high, .i_keypad_act, .i_serial_rx_int,
		.i_conv_int, .i_lowv_int, .i_dbg_halt_cmd, .i_dbg_go_cmd, .i_dbg_status_cmd,
		.o_rdata, .o_mode, .o_clk_en_cpu, .o_clk_en_periph, .o_clk_en_dbg, .o_osc_run,
		.o_reg_full, .o_pin_hold, .o_pin_port_ctl, .o_sys_reset, .o_illegal_reset,
		.o_wake_int, .o_vector, .o_dbg_active, .o_dbg_status_err
	);

	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask

	task report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	function automatic logic [7:0] lf(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction

	// wake sources in priority order map onto vectors 2 to 7
	function automatic logic [7:0] src_vec(input int i);
		return 8'(i + 2);
	endfunction

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1;
		chk("rdata", e, o_rdata);
	endtask

	task stp;
		@(posedge i_clk_sys);
		i_stop_exec <= 1'b1;
		@(posedge i_clk_sys);
		i_stop_exec <= 1'b0;
		#1;
	endtask

	task wait_run;
		int n;
		n = 0;
		#1;
		while (o_mode !== 2'b00 && n < 300) begin
			@(posedge i_clk_sys);
			#1;
			n++;
		end
		if (n >= 300) begin
			bad_count++;
			report_and_stop;
		end
	endtask

	initial begin
		repeat (3) @(posedge i_clk_sys);
		i_resetn <= 1'b1;
		#1;
		chk("state", 8'h3E, st);
		for (int k = 0; k < 4; k++) begin
			r = lf(r);
			wr(8'h00, r & 8'h0F);
			rd(8'h00, r & 8'h0F);
			wr(8'h01, r & 8'h1F);
			rd(8'h01, r & 8'h1F);
		end
		rd(8'h05, 8'h00);
		rd(8'h02, 8'h00);
		wr(8'h00, 8'h00);
		wr(8'h01, 8'h00);
		stp;
		chk("evt", 8'hC9, ev);
		chk("state", 8'h3E, st);
		wr(8'h00, 8'h03);
		stp;
		chk("state", 8'h81, st);
		@(posedge i_clk_sys);
		i_keypad_act <= 1'b1;
		i_irq_pol_high <= 1'b1;
		repeat (6) @(posedge i_clk_sys);
		#1;
		chk("state", 8'h81, st);
		@(posedge i_clk_sys);
		i_keypad_act <= 1'b0;
		i_irq_pin <= 1'b0;
		wait_run;
		chk("evt", 8'h81, ev);
		chk("state", 8'h3F, st);
		@(posedge i_clk_sys);
		i_irq_pin <= 1'b1;
		i_irq_pol_high <= 1'b0;
		rd(8'h00, 8'h20);
		// software would restore its port registers here, before the release
		wr(8'h00, 8'h10);
		rd(8'h00, 8'h00);
		chk("evt", 8'h08, ev);
		for (int i = 0; i < 6; i++) begin
			r = lf(r);
			wr(8'h00, r[0] ? 8'h0F : 8'h01);
			wr(8'h01, {4'h0, r[1], 2'b00, i == 2});
			stp;
			chk("state", 8'h40 | {5'h0, r[1], r[0], 1'b0}, st);
			@(posedge i_clk_sys);
			i_irq_pin <= (i != 0);
			i_keypad_act <= (i == 1);
			i_serial_rx_int <= (i == 3);
			i_conv_int <= (i == 4);
			i_lowv_int <= (i == 5);
			wait_run;
			chk("evt", 8'h28 | src_vec(i), ev);
			@(posedge i_clk_sys);
			i_irq_pin <= 1'b1;
			i_keypad_act <= 1'b0;
			i_serial_rx_int <= 1'b0;
			i_conv_int <= 1'b0;
			i_lowv_int <= 1'b0;
			repeat (3) @(posedge i_clk_sys);
		end
		wr(8'h01, 8'h10);
		wr(8'h00, 8'h03);
		stp;
		chk("state", 8'h4E, st);
		@(posedge i_clk_sys);
		i_dbg_status_cmd <= 1'b1;
		@(posedge i_clk_sys);
		i_dbg_status_cmd <= 1'b0;
		#1;
		chk("err", 8'h01, {7'h0, o_dbg_status_err});
		@(posedge i_clk_sys);
		i_dbg_halt_cmd <= 1'b1;
		@(posedge i_clk_sys);
		i_dbg_halt_cmd <= 1'b0;
		wait_run;
		chk("evt", 8'h18, ev);
		@(posedge i_clk_sys);
		i_dbg_go_cmd <= 1'b1;
		@(posedge i_clk_sys);
		i_dbg_go_cmd <= 1'b0;
		#1;
		chk("evt", 8'h08, ev);
		wr(8'h01, 8'h00);
		wr(8'h00, 8'h01);
		stp;
		@(posedge i_clk_sys);
		i_reset_pin_n <= 1'b0;
		wait_run;
		chk("evt", 8'h89, ev);
		@(posedge i_clk_sys);
		i_reset_pin_n <= 1'b1;
		repeat (3) @(posedge i_clk_sys);
		wr(8'h00, 8'h03);
		stp;
		repeat (100) @(posedge i_clk_sys);
		#1;
		chk("state", 8'h81, st);
		@(posedge i_clk_sys);
		i_irq_pin <= 1'b0;
		wait_run;
		chk("evt", 8'h81, ev);
		@(posedge i_clk_sys);
		i_irq_pin <= 1'b1;
		wr(8'h00, 8'h10);
		// periodic wake out of deep stop, select 1 gives 64 cycles
		wr(8'h01, 8'h01);
		wr(8'h00, 8'h03);
		stp;
		wait_run;
		chk("evt", 8'h81, ev);
		wr(8'h00, 8'h10);
		report_and_stop;
	end
endmodule // stop_mode_sequencer_test
